// >>> channel_diagnostic_status_tb_top.sv
// Testbench for the channel diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module channel_diagnostic_status_tb_top;
  logic        core_clk, rst_n, selftest_pass, selftest_recoverable;
  logic        module_fault_recov, module_fault_unrecov, net_online;
  logic        net_path_complete, net_fault_recov, net_fault_unrecov;
  logic        scan_strobe, field_power_ok, img_rd, img_rvalid;
  logic        operational;
  logic [3:0]  chan_enable, chan_cfg_valid, chan_under_range;
  logic [3:0]  chan_open_wire, chan_short, chan_cfg_error;
  logic [7:0]  chan_range, img_addr;
  logic [15:0] img_rdata, d, lit, dark;
  logic [2:0]  module_health_indicator, network_link_indicator;
  int          error_cnt, compares, n;

  // Short flash period keeps the run brief
  chds_top #(.FLASH_HALF_CYC(4)) u_dut (.*);
  chds_net_ctl u_host (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Lit and dark samples of one indicator over one flash period
  task automatic blink(input logic is_net, input logic [2:0] code,
                       output logic [15:0] on_cnt,
                       output logic [15:0] off_cnt);
    logic [2:0] ind;
    on_cnt = 16'h0000;
    off_cnt = 16'h0000;
    repeat (8)
    begin
      @(posedge core_clk);
      ind = is_net ? network_link_indicator : module_health_indicator;
      if (ind === code)
        on_cnt++;
      else if (ind === 3'h0)
        off_cnt++;
    end
  endtask

  task automatic results;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read lands one edge after the scan is taken
  task automatic scan_rd(output logic [15:0] w);
    fork
      begin
        @(posedge core_clk);
        scan_strobe <= 1'b1;
        @(posedge core_clk);
        scan_strobe <= 1'b0;
      end
      begin
        @(posedge core_clk);
        u_host.rd(8'h04, w);
      end
    join
  endtask

  initial
  begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    results();
  end

  initial
  begin
    {rst_n, selftest_recoverable, module_fault_recov} = 3'h0;
    {module_fault_unrecov, net_fault_recov, net_fault_unrecov} = 3'h0;
    {selftest_pass, net_online, net_path_complete} = 3'h7;
    {scan_strobe, chan_enable, chan_under_range} = 9'h000;
    {chan_open_wire, chan_short, chan_range} = 16'h0000;
    chan_cfg_valid = 4'hf;
    field_power_ok = 1'b1;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    scan_rd(d);
    chk("status_in_test", d, 16'h000f);
    for (n = 0; n < 20 && operational !== 1'b1; n++)
      @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk("operational", operational, 1'b1);
    chk("module_ind", module_health_indicator, 3'h3);
    chk("network_ind", network_link_indicator, 3'h3);
    $display("test startup done");
    for (n = 0; n < 4; n++)
    begin
      chan_under_range <= 4'h1 << n;
      scan_rd(d);
      chk("under_range_map", d, 16'h1 << n);
    end
    chan_range <= 8'h90;
    chan_under_range <= 4'h5;
    chan_open_wire <= 4'h2;
    chan_short <= 4'h8;
    scan_rd(d);
    chk("mixed_ranges", d, 16'h0003);
    field_power_ok <= 1'b0;
    scan_rd(d);
    chk("no_field_power", d, 16'h000f);
    {field_power_ok, chan_under_range, chan_open_wire} <= 9'h100;
    module_fault_recov <= 1'b1;
    scan_rd(d);
    chk("module_fault", d, 16'h000f);
    module_fault_recov <= 1'b0;
    u_host.rd(8'h05, d);
    chk("unmapped_read", d, 16'h0000);
    $display("test status word done");
    chan_range <= 8'h30;
    chan_enable <= 4'h4;
    repeat (3) @(posedge core_clk);
    chk("cfg_on_enable", chan_cfg_error, 4'h4);
    chan_cfg_valid <= 4'hd;
    chan_enable <= 4'h6;
    scan_rd(d);
    chk("cfg_on_scan", chan_cfg_error, 4'h6);
    chan_enable <= 4'h0;
    net_fault_unrecov <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("net_unrecov", network_link_indicator, 3'h1);
    {net_fault_unrecov, net_online} <= 2'h0;
    repeat (3) @(posedge core_clk);
    chk("net_offline", network_link_indicator, 3'h0);
    $display("test config and network done");
    net_online <= 1'b1;
    net_path_complete <= 1'b0;
    repeat (3) @(posedge core_clk);
    blink(1'b1, 3'h3, lit, dark);
    chk("net_green_flash", lit, 16'h0004);
    chk("net_green_dark", dark, 16'h0004);
    chk("mod_green_online", module_health_indicator, 3'h3);
    {net_fault_recov, module_fault_recov} <= 2'h3;
    repeat (3) @(posedge core_clk);
    blink(1'b1, 3'h1, lit, dark);
    chk("net_red_flash", lit, 16'h0004);
    blink(1'b0, 3'h1, lit, dark);
    chk("mod_red_flash", lit, 16'h0004);
    chk("mod_red_dark", dark, 16'h0004);
    {net_fault_recov, module_fault_recov, module_fault_unrecov} <= 3'h1;
    repeat (8) @(posedge core_clk);
    chk("runtime_fault_op", operational, 1'b0);
    chk("runtime_fault_ind", module_health_indicator, 3'h1);
    scan_rd(d);
    chk("runtime_fault_bits", d, 16'h000f);
    module_fault_unrecov <= 1'b0;
    $display("test flashing and runtime fault done");
    selftest_pass <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("selftest_fail_op", operational, 1'b0);
    chk("selftest_fail_ind", module_health_indicator, 3'h1);
    $display("test self-test fault done");
    selftest_recoverable <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    blink(1'b0, 3'h1, lit, dark);
    chk("selftest_recov_ind", lit, 16'h0004);
    chk("selftest_recov_op", operational, 1'b0);
    $display("test recoverable self-test fault done");
    results();
  end
endmodule
`default_nettype wire

// >>> chds_chan_check.v
// Per-channel fault classification
`timescale 1ns/1ps
`default_nettype none
`include "chds_consts.vh"

module chds_chan_check (
  // Channel condition
  input  wire [1:0] range_sel,
  input  wire       enabled,
  input  wire       cfg_valid,
  input  wire       under_range,
  input  wire       open_wire,
  input  wire       short_ckt,
  input  wire       field_power_ok,
  // Result
  output wire       chan_fault,
  output wire       cfg_error
);

  wire loop_mode;

  assign loop_mode = (range_sel == `CHDS_RANGE_4_20MA);
  // Invalid range code counts as a bad configuration
  assign cfg_error = enabled & (~cfg_valid | (range_sel == 2'h3));
  // Over-range is never an input here on purpose
  assign chan_fault = ~field_power_ok
                    | (loop_mode & (under_range | open_wire | short_ckt));

endmodule
`default_nettype wire

// >>> chds_consts.vh
// Constants for the channel diagnostic status block
`ifndef CHDS_CONSTS_VH
`define CHDS_CONSTS_VH

// Register map
`define CHDS_STATUS_WORD_OFF  8'h04
`define CHDS_STATUS_RESET     16'h0000
`define CHDS_NUM_CH           4

// Channel range codes
`define CHDS_RANGE_4_20MA     2'h0
`define CHDS_RANGE_0_20MA     2'h1
`define CHDS_RANGE_0_10V      2'h2

// Indicator codes
`define CHDS_IND_OFF          3'h0
`define CHDS_IND_RED          3'h1
`define CHDS_IND_RED_FLASH    3'h2
`define CHDS_IND_GREEN        3'h3
`define CHDS_IND_GREEN_FLASH  3'h4

// Timing: flash half period and self-test length
`define CHDS_FLASH_HALF_NS    250000000
`define CHDS_CLK_NS           8
`define CHDS_FLASH_HALF_CYC   (`CHDS_FLASH_HALF_NS / `CHDS_CLK_NS)
`define CHDS_SELFTEST_STEPS   4'h8

`endif

// >>> chds_flasher.v
// Flash phase generator for the status indicators
`timescale 1ns/1ps
`default_nettype none
`include "chds_consts.vh"

module chds_flasher #(
  parameter HALF_CYC = `CHDS_FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire core_clk,
  input  wire rst_n,
  // Phase
  output reg  phase
);

  reg [31:0] count;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 32'h0000_0000;
      phase <= 1'b0;
    end
    else if (count >= HALF_CYC - 1)
    begin
      count <= 32'h0000_0000;
      phase <= ~phase;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// >>> chds_net_ctl.sv
// Network controller model reading the input image
`timescale 1ns/1ps
`default_nettype none
module chds_net_ctl (
  // Clock
  input  wire logic        core_clk,
  // Input image read port
  output var  logic        img_rd,
  output var  logic [7:0]  img_addr,
  input  wire logic [15:0] img_rdata,
  input  wire logic        img_rvalid
);
  initial
  begin
    img_rd   = 1'b0;
    img_addr = 8'h00;
  end

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    begin
      d = 16'hdead;
      n = 0;
      @(posedge core_clk);
      img_rd   <= 1'b1;
      img_addr <= a;
      @(posedge core_clk);
      img_rd   <= 1'b0;
      // Released address never shows the last value
      img_addr <= ~a;
      while (n < 4)
      begin
        @(posedge core_clk);
        n = (img_rvalid === 1'b1) ? 4 : n + 1;
        if (img_rvalid === 1'b1)
          d = img_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> chds_top.v
// Channel diagnostic status: self-test, indicators, channel status word
// Notes on behaviour
// R01: Module indicator is steady red, flashing red, green, flashing green or off by module health.
// R02: Network indicator is steady red, flashing red, green, flashing green or off by link state.
// R03: Both indicators green only when powered and actively communicating; the module indicator goes green without net_path_complete.
// R04: Power-up self-tests must all pass before normal operation.
// R05: A channel's configuration is checked when it becomes enabled.
// R06: Every scan rechecks config, under-range and open wire (open wire in 4-20 mA only).
// R07: In 4-20 mA range an under-range sets that channel's status bit.
// R08: In 4-20 mA range an open circuit sets that channel's status bit.
// R09: Status bits 0 to 3 map to channels 0 to 3.
// R10: A bit is set for no field power, loop faults, and module faults set all bits.
// R11: Status bits 4 to 15 always read zero.
// R12: Over-range never sets a bit; other ranges flag only field power loss.
`timescale 1ns/1ps
`default_nettype none
`include "chds_consts.vh"

module chds_top #(
  parameter FLASH_HALF_CYC = `CHDS_FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Self-test results, one bit per step
  input  wire        selftest_pass,
  input  wire        selftest_recoverable,
  // Runtime module faults
  input  wire        module_fault_recov,
  input  wire        module_fault_unrecov,
  // Network link state
  input  wire        net_online,
  input  wire        net_path_complete,
  input  wire        net_fault_recov,
  input  wire        net_fault_unrecov,
  // Scan and channel conditions
  input  wire        scan_strobe,
  input  wire [3:0]  chan_enable,
  input  wire [7:0]  chan_range,
  input  wire [3:0]  chan_cfg_valid,
  input  wire [3:0]  chan_under_range,
  input  wire [3:0]  chan_open_wire,
  input  wire [3:0]  chan_short,
  input  wire        field_power_ok,
  // Input image read port
  input  wire        img_rd,
  input  wire [7:0]  img_addr,
  output reg  [15:0] img_rdata,
  output reg         img_rvalid,
  // Indicators and status
  output reg  [2:0]  module_health_indicator,
  output reg  [2:0]  network_link_indicator,
  output reg  [3:0]  chan_cfg_error,
  output reg         operational
);

  localparam ST_TEST  = 3'b001;
  localparam ST_RUN   = 3'b010;
  localparam ST_FAULT = 3'b100;

  reg  [2:0]  state;
  reg  [3:0]  test_step;
  reg         test_recov;
  reg  [3:0]  enable_q;
  reg  [15:0] status_word;
  reg  [2:0]  next_mod_ind;
  reg  [2:0]  next_net_ind;
  wire        flash;
  wire [3:0]  fault_vec;
  wire [3:0]  cfg_vec;
  wire        mod_fault_any;
  wire [3:0]  enable_rise;
  wire        test_last;
  reg  [3:0]  next_cfg_error;
  wire        channel0_fault_flag;
  wire        channel1_fault_flag;
  wire        channel2_fault_flag;
  wire        channel3_fault_flag;
  wire [3:0]  chan_flags;

  chds_flasher #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .phase    (flash)
  );

  genvar g;
  generate
    for (g = 0; g < `CHDS_NUM_CH; g = g + 1)
    begin : g_ch
      chds_chan_check u_chk (
        .range_sel      (chan_range[2*g+1:2*g]),
        .enabled        (chan_enable[g]),
        .cfg_valid      (chan_cfg_valid[g]),
        .under_range    (chan_under_range[g]),
        .open_wire      (chan_open_wire[g]),
        .short_ckt      (chan_short[g]),
        .field_power_ok (field_power_ok),
        .chan_fault     (fault_vec[g]),
        .cfg_error      (cfg_vec[g])
      );
    end
  endgenerate

  function [2:0] ind_blink;
    input [2:0] code;
    input       ph;
    begin
      if (code == `CHDS_IND_RED_FLASH)
        ind_blink = ph ? `CHDS_IND_RED : `CHDS_IND_OFF;
      else if (code == `CHDS_IND_GREEN_FLASH)
        ind_blink = ph ? `CHDS_IND_GREEN : `CHDS_IND_OFF;
      else
        ind_blink = code;
    end
  endfunction

  // Channel flags into the status word layout
  function [15:0] pack_status;
    input [3:0] flags;
    begin
      pack_status[15:4] = 12'h000; // [R11]
      pack_status[3:0]  = flags; // [R09]
    end
  endfunction

  // Only the status word answers; every other address reads zero
  function addr_is_status;
    input [7:0] addr;
    begin
      addr_is_status = (addr == `CHDS_STATUS_WORD_OFF);
    end
  endfunction

  // Not running counts as a fault, so stale data never reads clean
  assign mod_fault_any = module_fault_recov | module_fault_unrecov
                       | (state != ST_RUN);
  assign enable_rise   = chan_enable & ~enable_q;
  assign test_last     = (test_step == `CHDS_SELFTEST_STEPS - 4'h1);

  // Bit n follows channel n; a module fault sets every bit
  assign channel0_fault_flag = fault_vec[0] | mod_fault_any; // [R09] [R10]
  assign channel1_fault_flag = fault_vec[1] | mod_fault_any; // [R09] [R10]
  assign channel2_fault_flag = fault_vec[2] | mod_fault_any; // [R09] [R10]
  assign channel3_fault_flag = fault_vec[3] | mod_fault_any; // [R09] [R10]
  assign chan_flags = {channel3_fault_flag, channel2_fault_flag,
                       channel1_fault_flag, channel0_fault_flag};

  // Self-test sequence; each step must pass in order
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= ST_TEST;
      test_step  <= 4'h0;
      test_recov <= 1'b0;
    end
    else
    begin
      case (state)
        ST_TEST:
        begin
          if (!selftest_pass)
          begin
            state      <= ST_FAULT; // [R04]
            test_recov <= selftest_recoverable;
          end
          else if (test_last)
            state <= ST_RUN; // [R04]
          else
            test_step <= test_step + 4'h1;
        end
        ST_RUN:
        begin
          if (module_fault_unrecov)
          begin
            state      <= ST_FAULT;
            test_recov <= 1'b0;
          end
        end
        // Held until reset; only a restart reruns the tests
        ST_FAULT:
          state <= ST_FAULT;
        default:
          state <= ST_TEST;
      endcase
    end
  end

  // Module indicator code
  always @*
  begin
    case (state)
      ST_FAULT:
        if (test_recov)
          next_mod_ind = `CHDS_IND_RED_FLASH; // [R01]
        else
          next_mod_ind = `CHDS_IND_RED; // [R01]
      ST_TEST:
        next_mod_ind = `CHDS_IND_GREEN_FLASH; // [R01]
      ST_RUN:
      begin
        if (module_fault_recov)
          next_mod_ind = `CHDS_IND_RED_FLASH; // [R01]
        else if (!net_online)
          next_mod_ind = `CHDS_IND_GREEN_FLASH; // [R01]
        else
          next_mod_ind = `CHDS_IND_GREEN; // [R01] [R03]
      end
      default:
        next_mod_ind = `CHDS_IND_RED; // [R01]
    endcase
  end

  // Network indicator code
  always @*
  begin
    if (net_fault_unrecov)
      next_net_ind = `CHDS_IND_RED; // [R02]
    else if (net_fault_recov)
      next_net_ind = `CHDS_IND_RED_FLASH; // [R02]
    else if (!net_online)
      next_net_ind = `CHDS_IND_OFF; // [R02]
    else if (net_path_complete)
      next_net_ind = `CHDS_IND_GREEN; // [R02] [R03]
    else
      next_net_ind = `CHDS_IND_GREEN_FLASH; // [R02]
  end

  // Check on enable, recheck every scan, clear when disabled
  always @*
  begin
    next_cfg_error = (chan_cfg_error & chan_enable & ~enable_rise)
                   | (enable_rise & cfg_vec); // [R05]
    if (scan_strobe)
      next_cfg_error = cfg_vec; // [R06]
  end

  // Indicators and run flag
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      module_health_indicator <= `CHDS_IND_OFF;
      network_link_indicator  <= `CHDS_IND_OFF;
      operational             <= 1'b0;
    end
    else
    begin
      module_health_indicator <= ind_blink(next_mod_ind, flash);
      network_link_indicator  <= ind_blink(next_net_ind, flash);
      operational             <= (state == ST_RUN);
    end
  end

  // Channel configuration checks
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q       <= 4'h0;
      chan_cfg_error <= 4'h0;
    end
    else
    begin
      enable_q       <= chan_enable;
      chan_cfg_error <= next_cfg_error; // [R05] [R06]
    end
  end

  // Status word updated once per scan; holds between scans
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_word <= `CHDS_STATUS_RESET;
    else if (scan_strobe)
    begin
      // Taken only at scan end, so a read never sees a half scan
      status_word <= pack_status(chan_flags); // [R06] [R07] [R08] [R12]
    end
  end

  // Image read port; other addresses read zero
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      img_rdata  <= 16'h0000;
      img_rvalid <= 1'b0;
    end
    else
    begin
      img_rvalid <= img_rd;
      if (img_rd && addr_is_status(img_addr))
        img_rdata <= status_word; // [R09] [R11]
      else
        img_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// >>> chds_top_asserts.sv
// Port checker for the channel diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module chds_chk (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // Stimulus side
  input wire        scan_strobe,
  input wire        field_power_ok,
  input wire        net_online,
  input wire        net_path_complete,
  input wire        net_fault_recov,
  input wire        net_fault_unrecov,
  input wire        selftest_pass,
  input wire        selftest_recoverable,
  input wire        module_fault_unrecov,
  input wire [3:0]  chan_enable,
  input wire        img_rd,
  input wire [7:0]  img_addr,
  // Design outputs
  input wire [15:0] img_rdata,
  input wire        img_rvalid,
  input wire [2:0]  module_health_indicator,
  input wire [2:0]  network_link_indicator,
  input wire [3:0]  chan_cfg_error,
  input wire        operational
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (img_rd |=> img_rvalid)
    else $error("read answer missing");
  a_no_spurious: assert property (!img_rd |=> !img_rvalid)
    else $error("answer without request");
  a_upper_zero: assert property (
    img_rvalid |-> img_rdata[15:4] == 12'h000)
    else $error("unused status bits set");
  a_unmapped_zero: assert property (
    img_rd && img_addr != 8'h04 |=> img_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_nopower_all: assert property (
    scan_strobe && !field_power_ok ##1 img_rd && img_addr == 8'h04
    |=> img_rdata[3:0] == 4'hf)
    else $error("no field power not on all bits");
  a_net_green: assert property (
    network_link_indicator == 3'h3 |-> $past(net_online &&
    !net_fault_recov && !net_fault_unrecov))
    else $error("network green without link");
  a_net_complete: assert property (
    $past(rst_n) && $past(net_online && net_path_complete &&
    !net_fault_recov && !net_fault_unrecov)
    |-> network_link_indicator == 3'h3)
    else $error("complete path not steady green");
  a_net_unrec: assert property (
    net_fault_unrecov |=> network_link_indicator == 3'h1)
    else $error("network not red on fault");
  a_fault_hold: assert property (
    operational && module_fault_unrecov
    |=> ##1 module_health_indicator == 3'h1 [*8])
    else $error("runtime fault red not held");
  a_test_fail: assert property (
    $rose(rst_n) && !selftest_pass && !selftest_recoverable
    |=> ##1 module_health_indicator == 3'h1 [*8])
    else $error("self-test fault red not held");
  a_cfg_clear: assert property (
    chan_enable == 4'h0 |=> chan_cfg_error == 4'h0)
    else $error("config error on disabled channel");

  c_chan_bits: cover property (img_rvalid && img_rdata[3:0] == 4'h3);
  c_run: cover property ($rose(operational));
  c_net_red: cover property (network_link_indicator == 3'h1);
  c_fault_red: cover property (!operational &&
    module_health_indicator == 3'h1);
endmodule

bind chds_top chds_chk u_chk (.*);
`default_nettype wire
